// File: hw/afoc_pkg.sv
// constants for the audio format and output mode control block
package afoc_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          NUM_CH          = 6;
  // register offsets
  localparam logic [7:0]  FMT_OFS         = 8'h04;
  localparam logic [7:0]  SYS2_OFS        = 8'h05;
  localparam logic [7:0]  MUTE_OFS        = 8'h06;
  localparam logic [7:0]  SDG_OFS         = 8'h19;
  localparam logic [7:0]  STAT_OFS        = 8'h20;
  // reset values
  localparam logic [7:0]  FMT_RST         = 8'h05;
  localparam logic [7:0]  SYS2_RST        = 8'h40;
  localparam logic [7:0]  MUTE_RST        = 8'h00;
  localparam logic [7:0]  SDG_RST         = 8'h00;
  // writable masks: reserved bits read as zero
  localparam logic [7:0]  FMT_MASK        = 8'h1F;
  localparam logic [7:0]  SYS2_MASK       = 8'h6E;
  localparam logic [7:0]  MUTE_MASK       = 8'h2F;
  localparam logic [7:0]  SDG_MASK        = 8'h3F;
  // system control two fields
  localparam int          RUN_BIT         = 6;
  localparam int          CFG_BIT         = 5;
  localparam int          VOLSRC_BIT      = 3;
  localparam int          MODE_LSB        = 1;
  // format codes
  localparam logic [4:0]  FMT_RJ16        = 5'h00;
  localparam logic [4:0]  FMT_RJ20        = 5'h01;
  localparam logic [4:0]  FMT_RJ24        = 5'h02;
  localparam logic [4:0]  FMT_I2S16       = 5'h03;
  localparam logic [4:0]  FMT_I2S20       = 5'h04;
  localparam logic [4:0]  FMT_I2S24       = 5'h05;
  localparam logic [4:0]  FMT_LJ16        = 5'h06;
  localparam logic [4:0]  FMT_LJ20        = 5'h07;
  localparam logic [4:0]  FMT_LJ24        = 5'h08;
  localparam logic [4:0]  FMT_RJ18        = 5'h0A;
  localparam logic [4:0]  FMT_I2S16_32    = 5'h13;
  localparam logic [4:0]  FMT_LJ_32       = 5'h16;
  // word lengths and bit clock ratios
  localparam logic [4:0]  WL_16           = 5'h10;
  localparam logic [4:0]  WL_18           = 5'h12;
  localparam logic [4:0]  WL_20           = 5'h14;
  localparam logic [4:0]  WL_24           = 5'h18;
  localparam logic [6:0]  RATIO_64        = 7'h40;
  localparam logic [6:0]  RATIO_32        = 7'h20;
  // headphone and subwoofer channel indices in the enable vector
  localparam int          HP_CH           = 4;
  localparam int          SUB_CH          = 5;

  typedef enum logic [1:0] {
    AFOC_JUST_RIGHT,
    AFOC_JUST_I2S,
    AFOC_JUST_LEFT,
    AFOC_JUST_NONE
  } afoc_just_t;

  typedef enum logic [1:0] {
    AFOC_MODE_SPEAKER,
    AFOC_MODE_HEADPHONE,
    AFOC_MODE_LINEOUT,
    AFOC_MODE_RESERVED
  } afoc_mode_t;
endpackage

// File: hw/afoc_ctrl.sv
// audio format decode, playback run control and output mode selection
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module afoc_ctrl
  import afoc_pkg::*;
(
  // clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       resetn_i,
  // register port
  input  wire logic [afoc_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [afoc_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic      [afoc_pkg::DATA_W-1:0] reg_rdata_o,
  // pins
  input  wire logic                       headphone_select_pin_i,
  // decoded format
  output afoc_pkg::afoc_just_t            fmt_just_o,
  output logic      [4:0]                 fmt_word_len_o,
  output logic      [6:0]                 fmt_bclk_ratio_o,
  output logic                            fmt_reserved_o,
  // playback and output control
  output logic                            valid_o,
  output afoc_pkg::afoc_mode_t            out_mode_o,
  output logic      [afoc_pkg::NUM_CH-1:0] ch_run_o,
  output logic      [afoc_pkg::NUM_CH-1:0] ch_soft_mute_o,
  output logic                            headphone_pwm_outputs_en_o,
  output logic                            hp_use_hp_volume_o
);
  import afoc_pkg::*;

  logic [7:0] fmt_r;
  logic [7:0] sys2_r;
  logic [7:0] mute_r;
  logic [7:0] sdg_r;
  logic       headphone_select_pin_meta_r;
  logic       headphone_select_pin_sync_r;

  // register write decode
  wire wr_fmt  = reg_wr_i && (reg_addr_i == FMT_OFS);
  wire wr_sys2 = reg_wr_i && (reg_addr_i == SYS2_OFS);
  wire wr_mute = reg_wr_i && (reg_addr_i == MUTE_OFS);
  wire wr_sdg  = reg_wr_i && (reg_addr_i == SDG_OFS);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      fmt_r  <= FMT_RST;
      sys2_r <= SYS2_RST;
      mute_r <= MUTE_RST;
      sdg_r  <= SDG_RST;
    end else begin
      if (wr_fmt)
        fmt_r <= reg_wdata_i & FMT_MASK;
      if (wr_sys2)
        sys2_r <= reg_wdata_i & SYS2_MASK;
      if (wr_mute)
        mute_r <= reg_wdata_i & MUTE_MASK;
      if (wr_sdg)
        sdg_r <= reg_wdata_i & SDG_MASK;
    end
  end

  // headphone select pin is asynchronous to ref_clk
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      headphone_select_pin_meta_r <= 1'b0;
      headphone_select_pin_sync_r <= 1'b0;
    end else begin
      headphone_select_pin_meta_r <= headphone_select_pin_i;
      headphone_select_pin_sync_r <= headphone_select_pin_meta_r;
    end
  end

  // format decode
  afoc_just_t just_w;
  logic [4:0] wl_w;
  logic [6:0] ratio_w;
  logic       rsv_w;

  always_comb begin
    just_w  = AFOC_JUST_NONE;
    wl_w    = WL_24;
    ratio_w = RATIO_64;
    rsv_w   = 1'b0;
    unique case (fmt_r[4:0])
      FMT_RJ16: begin
        just_w = AFOC_JUST_RIGHT;
        wl_w   = WL_16;
      end
      FMT_RJ20: begin
        just_w = AFOC_JUST_RIGHT;
        wl_w   = WL_20;
      end
      FMT_RJ24:  just_w = AFOC_JUST_RIGHT;
      FMT_RJ18: begin
        just_w = AFOC_JUST_RIGHT;
        wl_w   = WL_18;
      end
      FMT_I2S16: begin
        just_w = AFOC_JUST_I2S;
        wl_w   = WL_16;
      end
      FMT_I2S20: begin
        just_w = AFOC_JUST_I2S;
        wl_w   = WL_20;
      end
      FMT_I2S24: just_w = AFOC_JUST_I2S;
      FMT_LJ16: begin
        just_w = AFOC_JUST_LEFT;
        wl_w   = WL_16;
      end
      FMT_LJ20: begin
        just_w = AFOC_JUST_LEFT;
        wl_w   = WL_20;
      end
      FMT_LJ24:  just_w = AFOC_JUST_LEFT;
      FMT_I2S16_32: begin
        just_w  = AFOC_JUST_I2S;
        wl_w    = WL_16;
        ratio_w = RATIO_32;
      end
      FMT_LJ_32: begin
        just_w  = AFOC_JUST_LEFT;
        ratio_w = RATIO_32;
      end
      default: rsv_w = 1'b1;
    endcase
  end

  // mode and run decode
  wire        run_stop = sys2_r[RUN_BIT];
  wire        cfg_all  = sys2_r[CFG_BIT];
  wire [1:0]  mode_bits = sys2_r[MODE_LSB+:2];
  afoc_mode_t mode_w;

  always_comb begin
    unique case (mode_bits)
      2'h0:    mode_w = headphone_select_pin_sync_r ? AFOC_MODE_HEADPHONE
                                     : AFOC_MODE_SPEAKER;
      2'h1:    mode_w = AFOC_MODE_HEADPHONE;
      2'h2:    mode_w = AFOC_MODE_LINEOUT;
      default: mode_w = AFOC_MODE_RESERVED;
    endcase
  end

  // channels 0..3 speaker, 4 headphone, 5 subwoofer
  wire [NUM_CH-1:0] grp_w  = cfg_all ? '0 : sdg_r[NUM_CH-1:0];
  wire [NUM_CH-1:0] base_w = run_stop ? '0 : ~grp_w;
  logic [NUM_CH-1:0] run_w;

  always_comb begin
    run_w = base_w;
    unique case (mode_w)
      AFOC_MODE_SPEAKER:   run_w[HP_CH] = 1'b0;
      AFOC_MODE_HEADPHONE: run_w = base_w & (NUM_CH'(1) << HP_CH);
      AFOC_MODE_LINEOUT:   run_w = base_w;
      AFOC_MODE_RESERVED:  run_w = '0;
    endcase
  end

  // soft-mute map: bits 0..3 and 5, bit 4 has no channel
  wire [NUM_CH-1:0] mute_w = {mute_r[SUB_CH], 1'b0, mute_r[3:0]};

  wire [7:0] rd_w = (reg_addr_i == FMT_OFS)  ? fmt_r  :
                    (reg_addr_i == SYS2_OFS) ? sys2_r :
                    (reg_addr_i == MUTE_OFS) ? mute_r :
                    (reg_addr_i == SDG_OFS)  ? sdg_r  :
                    (reg_addr_i == STAT_OFS) ? {1'b0, rsv_w, run_w} :
                    8'h00;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o                <= 8'h00;
      fmt_just_o                 <= AFOC_JUST_I2S;
      fmt_word_len_o             <= WL_24;
      fmt_bclk_ratio_o           <= RATIO_64;
      fmt_reserved_o             <= 1'b0;
      valid_o                    <= 1'b0;
      out_mode_o                 <= AFOC_MODE_SPEAKER;
      ch_run_o                   <= '0;
      ch_soft_mute_o             <= '0;
      headphone_pwm_outputs_en_o <= 1'b0;
      hp_use_hp_volume_o         <= 1'b1;
    end else begin
      reg_rdata_o                <= reg_rd_i ? rd_w : 8'h00;
      fmt_just_o                 <= just_w;
      fmt_word_len_o             <= wl_w;
      fmt_bclk_ratio_o           <= ratio_w;
      fmt_reserved_o             <= rsv_w;
      valid_o                    <= ~run_stop;
      out_mode_o                 <= mode_w;
      ch_run_o                   <= run_w;
      ch_soft_mute_o             <= mute_w;
      headphone_pwm_outputs_en_o <= run_w[HP_CH];
      // channel volumes take over when volume-source bit is set
      hp_use_hp_volume_o         <= ~sys2_r[VOLSRC_BIT];
    end
  end

  a_stop_kills_run: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) run_stop |=> (ch_run_o == '0 && !valid_o))
    else $error("channels run while stopped");

  a_hp_mode_only: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) mode_bits == 2'h1 |=> (ch_run_o[3:0] == 4'h0 &&
    ch_run_o[SUB_CH] == 1'b0))
    else $error("speaker channel runs in headphone mode");

  a_cfg_all_run: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) (!run_stop && cfg_all && mode_bits == 2'h2)
    |=> ch_run_o == '1)
    else $error("not all channels run");

  a_sdg_held_off: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) (!cfg_all) |=> ((ch_run_o & $past(sdg_r[NUM_CH-1:0]))
    == '0))
    else $error("shutdown group channel runs");

  a_fmt_32x: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) (fmt_r[4:0] == FMT_I2S16_32) |=>
    (fmt_bclk_ratio_o == RATIO_32 && fmt_just_o == AFOC_JUST_I2S))
    else $error("32x I2S decode wrong");

  a_fmt_reset: assert property (@(posedge ref_clk_i)
    !resetn_i |=> fmt_r == FMT_I2S24)
    else $error("format reset value wrong");

  a_lineout_pin: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) mode_bits == 2'h2 |=> out_mode_o == AFOC_MODE_LINEOUT)
    else $error("line-out mode not taken");

  a_mute_map: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) 1'b1 |=> (ch_soft_mute_o[3:0] == $past(mute_r[3:0]) &&
    ch_soft_mute_o[SUB_CH] == $past(mute_r[SUB_CH])))
    else $error("soft mute map wrong");

  // named run-bit writes, which the register takes and the outputs follow, and a read request
  sequence s_run_wr;
    wr_sys2 && !reg_wdata_i[RUN_BIT];
  endsequence

  sequence s_stop_wr;
    wr_sys2 && reg_wdata_i[RUN_BIT];
  endsequence

  sequence s_rd_req;
    reg_rd_i && !reg_wr_i;
  endsequence

  // the write edge loads sys2, the next edge loads valid
  a_run_sets_valid: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) s_run_wr |=> ##1 valid_o)
    else $error("valid not raised after run");

  a_stop_clr_valid: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) s_stop_wr |=> ##1 !valid_o)
    else $error("valid not cleared after stop");

  a_mute_readback: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) s_rd_req and (reg_addr_i == MUTE_OFS) |=>
    reg_rdata_o == $past(mute_r))
    else $error("soft mute read back wrong");

  a_fmt_readback: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) s_rd_req and (reg_addr_i == FMT_OFS) |=>
    reg_rdata_o == {3'b000, $past(fmt_r[4:0])})
    else $error("format read back wrong");

  a_mute_reset: assert property (@(posedge ref_clk_i)
    !resetn_i |=> ch_soft_mute_o == '0)
    else $error("soft mute not cleared by reset");

  a_hp_pin_mode: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) (mode_bits == 2'h0 && headphone_select_pin_sync_r) |=>
    out_mode_o == AFOC_MODE_HEADPHONE)
    else $error("pin does not select headphone");

  a_spk_mode: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) (mode_bits == 2'h0 && !headphone_select_pin_sync_r) |=>
    (out_mode_o == AFOC_MODE_SPEAKER && !ch_run_o[HP_CH]))
    else $error("speaker mode wrong");

  a_hp_force: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) mode_bits == 2'h1 |=> out_mode_o == AFOC_MODE_HEADPHONE)
    else $error("forced headphone mode not taken");

  a_lineout_all: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) (!run_stop && mode_bits == 2'h2) |=>
    (ch_run_o | $past(grp_w)) == '1)
    else $error("line-out channel left off");

  a_volsrc_hp: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) !sys2_r[VOLSRC_BIT] |=> hp_use_hp_volume_o)
    else $error("headphone volume not selected");

  a_volsrc_ch: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) sys2_r[VOLSRC_BIT] |=> !hp_use_hp_volume_o)
    else $error("channel volumes not selected");

  a_fmt_lj32: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) (fmt_r[4:0] == FMT_LJ_32) |=>
    (fmt_bclk_ratio_o == RATIO_32 && fmt_just_o == AFOC_JUST_LEFT))
    else $error("32x left-justified decode wrong");

  a_fmt_rsv: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) rsv_w |=>
    (fmt_reserved_o && fmt_just_o == AFOC_JUST_NONE))
    else $error("reserved format not flagged");

  // every listed code below 10000 runs the 64x bit clock
  a_ratio_64: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) (!rsv_w && !fmt_r[4]) |=> fmt_bclk_ratio_o == RATIO_64)
    else $error("64x bit clock not selected");

  // the headphone slot has no soft-mute bit of its own
  a_mute_hp_zero: assert property (@(posedge ref_clk_i) disable iff
    (!resetn_i) 1'b1 |=> !ch_soft_mute_o[HP_CH])
    else $error("headphone slot soft muted");
endmodule

// File: sim/afoc_hp_pin_model.sv
// model of the external headphone select source, moving off the clock
`timescale 1ns/1ps
module afoc_hp_pin_model (
  // request from the bench
  input  wire logic want_i,
  // pin into the block
  output logic      pin_o
);
  // the pin is asynchronous, so the block has to resync it
  initial pin_o = 1'b0;
  always @(want_i) pin_o <= #13 want_i;
endmodule

// File: sim/audio_format_and_output_mode_control_tb.sv
// self-checking bench for the format and output mode control block
`timescale 1ns/1ps
module audio_format_and_output_mode_control_tb;
  import afoc_pkg::*;
  logic        ref_clk_i;
  logic        resetn_i;
  logic [7:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_rdata_o;
  logic        pin_want;
  logic        hp_pin;
  afoc_just_t  fmt_just_o;
  logic [4:0]  fmt_word_len_o;
  logic [6:0]  fmt_bclk_ratio_o;
  logic        fmt_reserved_o;
  logic        valid_o;
  afoc_mode_t  out_mode_o;
  logic [5:0]  ch_run_o;
  logic [5:0]  ch_soft_mute_o;
  logic        hp_en;
  logic        hp_vol;
  logic        rd_q;
  logic [7:0]  rd_exp[$];
  int          failures;
  int          samples_checked;
  int          seed;
  logic [14:0] fe;
  logic [5:0]  grp;
  logic [7:0]  mv;

  afoc_hp_pin_model pin_src (.want_i(pin_want), .pin_o(hp_pin));
  afoc_ctrl DUT (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .headphone_select_pin_i(hp_pin),
    .fmt_just_o(fmt_just_o), .fmt_word_len_o(fmt_word_len_o),
    .fmt_bclk_ratio_o(fmt_bclk_ratio_o), .fmt_reserved_o(fmt_reserved_o),
    .valid_o(valid_o), .out_mode_o(out_mode_o), .ch_run_o(ch_run_o),
    .ch_soft_mute_o(ch_soft_mute_o), .headphone_pwm_outputs_en_o(hp_en),
    .hp_use_hp_volume_o(hp_vol));

  task automatic close_out;
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    rd_exp.push_back(e);
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b0;
  endtask
  // derived outputs land one edge after the write edge
  task automatic settle;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic outs(logic v, afoc_mode_t m, logic [5:0] r);
    chk("valid", v, valid_o);
    chk("mode", m, out_mode_o);
    chk("ch_run", r, ch_run_o);
    chk("hp_en", r[HP_CH], hp_en);
  endtask
  function automatic logic [14:0] fexp(logic [4:0] c);
    case (c)
      FMT_RJ16:     return {AFOC_JUST_RIGHT, WL_16, RATIO_64, 1'b0};
      FMT_RJ20:     return {AFOC_JUST_RIGHT, WL_20, RATIO_64, 1'b0};
      FMT_RJ24:     return {AFOC_JUST_RIGHT, WL_24, RATIO_64, 1'b0};
      FMT_I2S16:    return {AFOC_JUST_I2S, WL_16, RATIO_64, 1'b0};
      FMT_I2S20:    return {AFOC_JUST_I2S, WL_20, RATIO_64, 1'b0};
      FMT_I2S24:    return {AFOC_JUST_I2S, WL_24, RATIO_64, 1'b0};
      FMT_LJ16:     return {AFOC_JUST_LEFT, WL_16, RATIO_64, 1'b0};
      FMT_LJ20:     return {AFOC_JUST_LEFT, WL_20, RATIO_64, 1'b0};
      FMT_LJ24:     return {AFOC_JUST_LEFT, WL_24, RATIO_64, 1'b0};
      FMT_RJ18:     return {AFOC_JUST_RIGHT, WL_18, RATIO_64, 1'b0};
      FMT_I2S16_32: return {AFOC_JUST_I2S, WL_16, RATIO_32, 1'b0};
      FMT_LJ_32:    return {AFOC_JUST_LEFT, WL_24, RATIO_32, 1'b0};
      default:      return {AFOC_JUST_NONE, 12'h000, 1'b1};
    endcase
  endfunction

  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk_i) rd_q <= reg_rd_i;
  always @(negedge ref_clk_i) begin
    if (rd_q === 1'b1)
      chk("rdata", rd_exp.pop_front(), reg_rdata_o);
  end
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    failures++;
    close_out();
  end
  initial begin
    seed = 32'hD624;
    {resetn_i, reg_wr_i, reg_rd_i, pin_want, rd_q} = 5'h00;
    {reg_addr_i, reg_wdata_i} = 16'h0000;
    failures = 0;
    samples_checked = 0;
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    #1;
    chk("fmt_rst", {AFOC_JUST_I2S, WL_24, RATIO_64}, {fmt_just_o,
        fmt_word_len_o, fmt_bclk_ratio_o});
    outs(1'b0, AFOC_MODE_SPEAKER, 6'h00);
    chk("hp_vol", 1'b1, hp_vol);
    chk("mute", 6'h00, ch_soft_mute_o);
    rd(FMT_OFS, 8'h05);
    rd(SYS2_OFS, 8'h40);
    rd(MUTE_OFS, 8'h00);
    for (int c = 0; c < 32; c++) begin
      fe = fexp(5'(c));
      wr(FMT_OFS, 8'(c));
      settle();
      if (fe[0])
        chk("fmt_res", {fe[14:13], 1'b1}, {fmt_just_o, fmt_reserved_o});
      else
        chk("fmt", fe, {fmt_just_o, fmt_word_len_o, fmt_bclk_ratio_o,
            fmt_reserved_o});
      rd(FMT_OFS, 8'(c));
    end
    // first write sets stop, later configuration changes while running
    wr(SYS2_OFS, 8'h60);
    wr(SYS2_OFS, 8'h20);
    settle();
    outs(1'b1, AFOC_MODE_SPEAKER, 6'h2F);
    wr(SYS2_OFS, 8'h22);
    settle();
    outs(1'b1, AFOC_MODE_HEADPHONE, 6'h10);
    chk("hp_vol", 1'b1, hp_vol);
    // line-out always with the volume-source bit
    wr(SYS2_OFS, 8'h2C);
    pin_want <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1;
    outs(1'b1, AFOC_MODE_LINEOUT, 6'h3F);
    chk("hp_vol", 1'b0, hp_vol);
    rd(SYS2_OFS, 8'h2C);
    wr(SYS2_OFS, 8'h20);
    settle();
    outs(1'b1, AFOC_MODE_HEADPHONE, 6'h10);
    pin_want <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1;
    outs(1'b1, AFOC_MODE_SPEAKER, 6'h2F);
    wr(SYS2_OFS, 8'h26);
    settle();
    outs(1'b1, AFOC_MODE_RESERVED, 6'h00);
    wr(SYS2_OFS, 8'h60);
    wr(SYS2_OFS, 8'h40);
    settle();
    outs(1'b0, AFOC_MODE_SPEAKER, 6'h00);
    grp = 6'($random(seed));
    wr(SDG_OFS, {2'b00, grp});
    wr(SYS2_OFS, 8'h00);
    settle();
    outs(1'b1, AFOC_MODE_SPEAKER, 6'h2F & ~grp);
    wr(SYS2_OFS, 8'h0C);
    settle();
    outs(1'b1, AFOC_MODE_LINEOUT, 6'h3F & ~grp);
    rd(STAT_OFS, {2'b01, 6'h3F & ~grp});
    wr(SYS2_OFS, 8'h4C);
    repeat (4) begin
      mv = 8'($random(seed));
      wr(MUTE_OFS, mv);
      settle();
      chk("mute", 6'(mv & 8'h2F), ch_soft_mute_o);
      rd(MUTE_OFS, mv & 8'h2F);
    end
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    rd(SYS2_OFS, 8'h4C);
    rd(STAT_OFS, 8'h40);
    repeat (3) @(posedge ref_clk_i);
    close_out();
  end
endmodule
